// >>> include/brc_cfg.svh
// constants of the burst readback crc block
`ifndef BRC_CFG_SVH
`define BRC_CFG_SVH
`define BRC_CRC_W 32
`define BRC_CRC_PRESET 32'hFFFF_FFFF
`define BRC_CRC_XOROUT 32'hFFFF_FFFF
`define BRC_CRC_POLY 32'hEDB8_8320
`define BRC_CRC_TAB1 32'h7707_3096
`define BRC_WORD_W 16
`define BRC_BYTE_W 8
`define BRC_BYTE_STEPS 8
`define BRC_CNT_W 4
`define BRC_WORDS_LAST 4'hE
`define BRC_WORDS_TOTAL 4'hF
`define BRC_FIFO_DEPTH 16
`endif

// >>> include/brc_pkg.sv
// types shared by the burst readback crc block
`include "brc_cfg.svh"
`default_nettype none
package brc_pkg;
   typedef enum logic [3:0]
   {
      BRC_IDLE = 4'h1,
      BRC_LOW = 4'h2,
      BRC_HIGH = 4'h4,
      BRC_FIN = 4'h8
   } brc_state_t;
   typedef struct packed
   {
      logic valid;
      logic [`BRC_WORD_W-1:0] data;
   } brc_word_t;
   typedef struct packed
   {
      logic fresh;
      logic [`BRC_CRC_W-1:0] value;
   } brc_sum_t;
   typedef struct packed
   {
      brc_state_t st;
      logic [`BRC_CRC_W-1:0] acc;
      logic [`BRC_BYTE_W-1:0] hi;
      logic [`BRC_CNT_W-1:0] cnt;
      logic [`BRC_CRC_W-1:0] crc;
      logic done;
      logic tog;
   } brc_core_t;
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic [`BRC_CRC_W-1:0] crc;
      logic fresh;
   } brc_link_t;
endpackage
`default_nettype wire

// >>> verilog/brc_fifo.sv
// word fifo with valid and ready on both sides
`include "brc_cfg.svh"
`default_nettype none
module brc_fifo #(
   parameter int W = `BRC_WORD_W,
   parameter int D = `BRC_FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   // depth must be a power of two so the pointers wrap on their own
   localparam int AW = $clog2(D);
   typedef struct packed
   {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic rdy;
   } brc_fifo_st_t;
   localparam brc_fifo_st_t RST = '{mem: '0, wr: '0, rd: '0, cnt: '0,
                                    rdy: 1'b1};
   brc_fifo_st_t st_r;
   brc_fifo_st_t st_nxt;
   logic push;
   logic pop;

   always_comb
   begin
      st_nxt = st_r;
      push = in_valid && st_r.rdy;
      pop = (st_r.cnt != '0) && out_ready;
      if (push)
      begin
         st_nxt.mem[st_r.wr] = in_data;
         st_nxt.wr = st_r.wr + AW'(1);
      end
      if (pop)
      begin
         st_nxt.rd = st_r.rd + AW'(1);
      end
      if (push && !pop)
      begin
         st_nxt.cnt = st_r.cnt + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
         st_nxt.cnt = st_r.cnt - (AW+1)'(1);
      end
      // registered ready keeps the fill side free of combinational paths
      st_nxt.rdy = st_nxt.cnt < (AW+1)'(D);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r <= RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign in_ready = st_r.rdy;
   assign out_valid = st_r.cnt != '0;
   assign out_data = st_r.mem[st_r.rd];
endmodule
`default_nettype wire

// >>> verilog/brc_crc.sv
// crc32 over the fifteen readback words of each sample cycle
`include "brc_cfg.svh"
`default_nettype none
module brc_crc
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic link_clk,
   input wire logic sample_ready_strobe,
   input wire brc_pkg::brc_word_t word_in,
   output logic word_ready,
   output brc_pkg::brc_sum_t sum_out,
   output brc_pkg::brc_sum_t link_sum_out
);
   brc_pkg::brc_core_t core_r;
   brc_pkg::brc_core_t core_nxt;
   brc_pkg::brc_link_t link_r;
   brc_pkg::brc_link_t link_nxt;
   logic fifo_in_ready;
   logic fifo_valid;
   logic [`BRC_WORD_W-1:0] fifo_data;
   logic fifo_take;
   logic pop;

   // one byte per cycle: eight serial steps folded into one function
   function automatic logic [`BRC_CRC_W-1:0] brc_step8
   (
      input logic [`BRC_CRC_W-1:0] crc_in,
      input logic [`BRC_BYTE_W-1:0] byte_in
   );
      logic [`BRC_CRC_W-1:0] c;
      c = crc_in ^ {{(`BRC_CRC_W-`BRC_BYTE_W){1'b0}}, byte_in};
      for (int j = 0; j < `BRC_BYTE_STEPS; j++)
      begin
         if (c[0])
         begin
            c = (c >> 1) ^ `BRC_CRC_POLY;
         end
         else
         begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

   // words wait here while the engine spends two cycles on each one
   brc_fifo #(
      .W(`BRC_WORD_W),
      .D(`BRC_FIFO_DEPTH)
   )
   u_fifo
   (
      .clk(clk),
      .rstn(rstn),
      .in_valid(word_in.valid),
      .in_data(word_in.data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_take)
   );

   // the engine drains in the low phase; idle words are stale and dropped
   // a strobe in the low phase leaves the waiting word for the new cycle
   assign fifo_take = (core_r.st == brc_pkg::BRC_IDLE) ||
                      ((core_r.st == brc_pkg::BRC_LOW) &&
                       !sample_ready_strobe);
   assign pop = fifo_valid && (core_r.st == brc_pkg::BRC_LOW);

   always_comb
   begin
      core_nxt = core_r;
      core_nxt.done = 1'b0;
      // strobe always wins: a late word set must not leak into the new one
      if (sample_ready_strobe)
      begin
         core_nxt.st = brc_pkg::BRC_LOW;
         core_nxt.acc = `BRC_CRC_PRESET;
         core_nxt.cnt = '0;
      end
      else
      begin
         case (core_r.st)
            brc_pkg::BRC_IDLE:
            begin
               core_nxt.st = brc_pkg::BRC_IDLE;
            end
            brc_pkg::BRC_LOW:
            begin
               if (pop)
               begin
                  core_nxt.acc = brc_step8(core_r.acc,
                                           fifo_data[`BRC_BYTE_W-1:0]);
                  core_nxt.hi = fifo_data[`BRC_WORD_W-1:`BRC_BYTE_W];
                  core_nxt.st = brc_pkg::BRC_HIGH;
               end
            end
            brc_pkg::BRC_HIGH:
            begin
               core_nxt.acc = brc_step8(core_r.acc, core_r.hi);
               core_nxt.cnt = core_r.cnt + `BRC_CNT_W'(1);
               if (core_r.cnt == `BRC_WORDS_LAST)
               begin
                  core_nxt.st = brc_pkg::BRC_FIN;
               end
               else
               begin
                  core_nxt.st = brc_pkg::BRC_LOW;
               end
            end
            brc_pkg::BRC_FIN:
            begin
               core_nxt.crc = core_r.acc ^ `BRC_CRC_XOROUT;
               core_nxt.done = 1'b1;
               core_nxt.tog = ~core_r.tog;
               core_nxt.st = brc_pkg::BRC_IDLE;
            end
            default:
            begin
               core_nxt.st = brc_pkg::BRC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         core_r <= '{st: brc_pkg::BRC_IDLE, acc: `BRC_CRC_PRESET, hi: '0,
                     cnt: '0, crc: '0, done: 1'b0, tog: 1'b0};
      end
      else
      begin
         core_r <= core_nxt;
      end
   end

   // link side: toggle handshake; the sum is held at least thirty cycles,
   // far longer than the three link edges the capture needs
   always_comb
   begin
      link_nxt = link_r;
      link_nxt.s1 = core_r.tog;
      link_nxt.s2 = link_r.s1;
      link_nxt.s3 = link_r.s2;
      link_nxt.fresh = link_r.s2 ^ link_r.s3;
      if (link_r.s2 ^ link_r.s3)
      begin
         link_nxt.crc = core_r.crc;
      end
   end

   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         link_r <= '0;
      end
      else
      begin
         link_r <= link_nxt;
      end
   end

   assign word_ready = fifo_in_ready;
   assign sum_out = {core_r.done, core_r.crc};
   assign link_sum_out = {link_r.fresh, link_r.crc};

   preset_on_strobe_a: assert property (
      @(posedge clk) disable iff (!rstn)
      sample_ready_strobe |=> (core_r.acc == `BRC_CRC_PRESET) &&
                              (core_r.cnt == '0) &&
                              (core_r.st == brc_pkg::BRC_LOW))
      else $error("accumulator not preset after strobe");

   word_in_order_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (pop && !sample_ready_strobe) |=>
         (core_r.hi == $past(fifo_data[`BRC_WORD_W-1:`BRC_BYTE_W])) &&
         (core_r.cnt == $past(core_r.cnt)))
      else $error("popped word not held for its high byte");

   final_invert_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_FIN && !sample_ready_strobe) |=>
         core_r.done && (core_r.crc == ($past(core_r.acc) ^
                                        `BRC_CRC_XOROUT)))
      else $error("published sum is not the inverted accumulator");

   fifteen_words_a: assert property (
      @(posedge clk) disable iff (!rstn)
      $rose(core_r.done) |-> $past(core_r.cnt) == `BRC_WORDS_TOTAL)
      else $error("sum published after a word count other than fifteen");

   one_sum_per_cycle_a: assert property (
      @(posedge clk) disable iff (!rstn)
      core_r.done |=> (!core_r.done)[*8])
      else $error("more than one sum in one sample cycle");

   low_byte_first_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (pop && !sample_ready_strobe) |=>
         core_r.acc == brc_step8($past(core_r.acc),
                                 $past(fifo_data[`BRC_BYTE_W-1:0])))
      else $error("low byte not folded first");

   high_byte_next_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_HIGH && !sample_ready_strobe) |=>
         (core_r.acc == brc_step8($past(core_r.acc), $past(core_r.hi))) &&
         (core_r.cnt == $past(core_r.cnt) + `BRC_CNT_W'(1)))
      else $error("high byte not folded after low byte");

   poly_table_a: assert property (
      @(posedge clk) disable iff (!rstn)
      core_r.done |-> brc_step8('0, 8'h01) == `BRC_CRC_TAB1)
      else $error("byte step does not match reflected polynomial");

   bit_steps_a: assert property (
      @(posedge clk) disable iff (!rstn)
      core_r.done |-> brc_step8('0, 8'h80) == `BRC_CRC_POLY)
      else $error("byte step not built from single-bit steps");

   word_two_cycles_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (pop && !sample_ready_strobe) |=> core_r.st == brc_pkg::BRC_HIGH
         ##1 (core_r.st != brc_pkg::BRC_HIGH))
      else $error("word not processed in exactly two cycles");

   link_copy_a: assert property (
      @(posedge link_clk) disable iff (!rstn)
      link_r.fresh |-> link_r.crc == core_r.crc)
      else $error("link copy differs from the published sum");

   fifo_stall_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_HIGH && fifo_valid) |=>
         fifo_valid && $stable(fifo_data))
      else $error("fifo drained during high byte phase");

   idle_no_sum_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_IDLE && !sample_ready_strobe) |=>
         (core_r.st == brc_pkg::BRC_IDLE) && !core_r.done)
      else $error("sum without a new sample cycle");

   sum_held_a: assert property (
      @(posedge clk) disable iff (!rstn)
      !core_r.done |->
         $stable(core_r.crc))
      else $error("published sum changed without a fresh pulse");

   toggle_per_sum_a: assert property (
      @(posedge clk) disable iff (!rstn)
      core_r.done ==
         (core_r.tog != $past(core_r.tog)))
      else $error("link toggle out of step with the sum pulse");

   fin_after_last_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_FIN) |->
         ($past(core_r.st) == brc_pkg::BRC_HIGH) &&
         ($past(core_r.cnt) == `BRC_WORDS_LAST))
      else $error("final step reached before the fifteenth word");

   count_in_range_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_LOW || core_r.st == brc_pkg::BRC_HIGH) |->
         core_r.cnt <= `BRC_WORDS_LAST)
      else $error("word count past fifteen in a busy phase");

   strobe_drops_sum_a: assert property (
      @(posedge clk) disable iff (!rstn)
      sample_ready_strobe |=>
         !core_r.done)
      else $error("sum published on a restarted cycle");

   high_after_low_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_HIGH) |->
         ($past(core_r.st) == brc_pkg::BRC_LOW))
      else $error("high byte phase without a low byte phase");

   low_waits_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_LOW && !pop && !sample_ready_strobe) |=>
         (core_r.st == brc_pkg::BRC_LOW) && $stable(core_r.acc))
      else $error("accumulator moved with no word to fold");

   taken_word_queued_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (word_in.valid && word_ready) |=>
         fifo_valid)
      else $error("accepted word not queued for the engine");

   link_fresh_once_a: assert property (
      @(posedge link_clk) disable iff (!rstn)
      link_r.fresh |=>
         !link_r.fresh)
      else $error("link fresh flag longer than one link cycle");

   link_sum_held_a: assert property (
      @(posedge link_clk) disable iff (!rstn)
      !link_r.fresh |->
         $stable(link_r.crc))
      else $error("link sum changed without a fresh flag");

   link_edge_seen_a: assert property (
      @(posedge link_clk) disable iff (!rstn)
      link_r.fresh ==
         (link_r.s3 != $past(link_r.s3)))
      else $error("link fresh flag not tied to a toggle edge");

   done_after_fin_a: assert property (
      @(posedge clk) disable iff (!rstn)
      core_r.done |->
         ($past(core_r.st) == brc_pkg::BRC_FIN))
      else $error("sum pulse without the final inversion step");

   preset_first_word_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_LOW && core_r.cnt == '0) |->
         core_r.acc == `BRC_CRC_PRESET)
      else $error("first word folded into a stale accumulator");

   cnt_low_hold_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (core_r.st == brc_pkg::BRC_LOW && !sample_ready_strobe) |=>
         core_r.cnt == $past(core_r.cnt))
      else $error("word count moved in the low byte phase");

endmodule
`default_nettype wire

// >>> verification/brc_host.sv
// host model: feeds readback words, collects link-side sums
`default_nettype none
module brc_host
(
   input wire logic clk,
   input wire logic link_clk,
   input wire logic word_ready,
   input wire brc_pkg::brc_sum_t link_sum,
   output brc_pkg::brc_word_t word_out,
   output logic [31:0] got,
   output logic got_v
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      word_out = '0;
      got = '0;
      got_v = 1'b0;
   end
   always @(posedge link_clk)
   begin
      got_v <= link_sum.fresh;
      if (link_sum.fresh)
         got <= link_sum.value;
   end
   // one word, held until ready is seen at a falling edge, then through the next rising edge
   task automatic send(input logic [15:0] w, input int gap,
      output bit ok);
      word_out <= {1'b1, w};
      ok = 0;
      for (int t = 0; t < 100 && !ok; t++)
      begin
         @(negedge clk);
         ok = word_ready;
      end
      @(posedge clk);
      if (gap > 0)
      begin
         // released data shows the inverse, never the stale word
         word_out <= {1'b0, ~w};
         repeat (gap) @(posedge clk);
      end
   endtask
   task automatic idle;
      word_out <= {1'b0, ~word_out.data};
   endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the burst readback crc block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, link_clk, rstn, strobe, word_ready, got_v;
   logic [31:0] got;
   brc_pkg::brc_word_t word_in;
   brc_pkg::brc_sum_t sum_out, link_sum_out;
   int err_total = 0;
   int compares = 0;
   logic [15:0] wq[15];
   brc_crc dut(.clk(clk), .rstn(rstn), .link_clk(link_clk),
      .sample_ready_strobe(strobe), .word_in(word_in),
      .word_ready(word_ready), .sum_out(sum_out),
      .link_sum_out(link_sum_out));
   brc_host host(.clk(clk), .link_clk(link_clk),
      .word_ready(word_ready), .link_sum(link_sum_out),
      .word_out(word_in), .got(got), .got_v(got_v));
   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      link_clk = 0;
      #7;
      forever #62.5 link_clk = ~link_clk;
   end
   task automatic check(input logic [32:0] seen,
      input logic [32:0] exp, input string msg);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   function automatic logic [31:0] ref_sum();
      logic [31:0] c;
      logic [7:0] b;
      c = 32'hFFFFFFFF;
      for (int i = 0; i < 15; i++)
         for (int k = 0; k < 2; k++)
         begin
            b = k ? wq[i][15:8] : wq[i][7:0];
            c ^= {24'h0, b};
            for (int j = 0; j < 8; j++)
               c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
         end
      return c ^ 32'hFFFFFFFF;
   endfunction
   task automatic pulse;
      @(posedge clk);
      strobe <= 1'b1;
      @(posedge clk);
      strobe <= 1'b0;
   endtask
   // the whole burst goes out inside one sample cycle
   task automatic feed(input int n, input int gap);
      bit ok;
      for (int i = 0; i < n; i++)
      begin
         host.send(wq[i], gap, ok);
         if (!ok)
         begin
            check(0, 1, "word not taken");
            close_out();
         end
      end
      host.idle();
   endtask
   task automatic wait_sum;
      logic [31:0] e;
      int t;
      e = ref_sum();
      for (t = 0; t < 200 && sum_out.fresh !== 1'b1; t++)
         @(negedge clk);
      if (t == 200)
      begin
         check(0, 1, "no sum");
         close_out();
      end
      check(sum_out.value, e, "sum value");
      @(negedge clk);
      check(sum_out.fresh, 0, "fresh not one cycle");
      for (t = 0; t < 20 && got_v !== 1'b1; t++)
         @(negedge clk);
      if (t == 20)
      begin
         check(0, 1, "no link sum");
         close_out();
      end
      check(got, e, "link sum value");
   endtask
   task automatic t_plain;
      for (int i = 0; i < 15; i++)
         wq[i] = {8'(i * 17 + 3), 8'(8'hA5 ^ i)};
      pulse();
      feed(15, 0);
      wait_sum();
      $display("test plain done");
   endtask
   task automatic t_again;
      for (int i = 0; i < 15; i++)
         wq[i] = 16'hFFFF - 16'(i * 257);
      pulse();
      feed(15, 3);
      wait_sum();
      $display("test slow repeat done");
   endtask
   task automatic t_restart;
      logic [31:0] prev;
      prev = ref_sum();
      for (int i = 0; i < 15; i++)
         wq[i] = 16'h0000;
      pulse();
      feed(7, 0);
      repeat (20) @(posedge clk);
      @(negedge clk);
      check(sum_out, {1'b0, prev}, "sum from a short burst");
      wq[14] = 16'h8001;
      pulse();
      feed(15, 0);
      wait_sum();
      $display("test restart done");
   endtask
   initial
   begin
      rstn = 1'b0;
      strobe = 1'b0;
      repeat (6) @(posedge clk);
      check(word_ready, 1, "ready in reset");
      check(sum_out, 0, "sum in reset");
      check(link_sum_out, 0, "link sum in reset");
      rstn <= 1'b1;
      t_plain();
      t_again();
      t_restart();
      close_out();
   end
endmodule
`default_nettype wire
